// [rtl/aux_line_drive.sv]
// output side of one second control line
`timescale 1ns/100ps
module aux_line_drive (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control
  input wire logic [5:0] ctrl,
  input wire logic strobe_edge,
  input wire logic data_event,
  // pin
  output logic line_out,
  output logic line_oe
);

  pia_lines_pkg::aux_mode_t mode;

  assign mode = pia_lines_pkg::aux_mode(ctrl);

  // ==========================================================
  // pin enable follows output mode
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      line_oe <= 1'b0;
    end else begin
      line_oe <= ctrl[pia_lines_pkg::CTRL_AUX_OUTPUT];
    end
  end

  // ==========================================================
  // output level per mode
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      line_out <= pia_lines_pkg::LINE_IDLE;
    end else begin
      unique case (mode)
        pia_lines_pkg::AUX_INPUT: begin
          line_out <= pia_lines_pkg::LINE_IDLE;
        end
        pia_lines_pkg::AUX_HANDSHAKE: begin
          if (strobe_edge) begin
            line_out <= 1'b1;
          end else if (data_event) begin
            line_out <= 1'b0;
          end
        end
        pia_lines_pkg::AUX_PULSE: begin
          line_out <= ~data_event;
        end
        pia_lines_pkg::AUX_MANUAL: begin
          line_out <= ctrl[pia_lines_pkg::CTRL_AUX_BIT3];
        end
      endcase
    end
  end

endmodule

// [rtl/line_edge_detect.sv]
// synchroniser and selectable edge detector for one control input
`timescale 1ns/100ps
module line_edge_detect (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // line
  input wire logic line_in,
  input wire logic rising_sel,
  // result
  output logic edge_seen
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // ==========================================================
  // two-stage synchroniser then previous sample
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_q <= pia_lines_pkg::LINE_IDLE;
      sync2_q <= pia_lines_pkg::LINE_IDLE;
      prev_q <= pia_lines_pkg::LINE_IDLE;
    end else begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // one pulse per transition, polarity chosen by rising_sel
  always_comb begin
    if (rising_sel) begin
      edge_seen = sync2_q & ~prev_q;
    end else begin
      edge_seen = ~sync2_q & prev_q;
    end
  end

endmodule

// [rtl/pia_control_lines.sv]
// control-line logic of a two-port peripheral interface adapter
// Contract
// - port B strobe input sets port B flag bit 7 and raises aux in B handshake.
// - bit 1 picks strobe edge; bit 0 lets flag 7 pull request low.
// - flag bit 7 sets on every active strobe edge, enable or not.
// - bit 5 clear makes aux line input; bit 4 edge, bit 3 enable.
// - flag bit 6 sets on every active aux edge in input mode.
// - port B aux line offers the same input modes as port A.
// - A handshake: aux high on strobe edge, low on port A data read.
// - A pulse: aux low one cycle after each port A data read.
// - port B output modes trigger on port B data writes, not reads.
// - B handshake: aux low on port B write, high on strobe edge.
// - B pulse: aux low one cycle after each port B data write.
// - reading a port's data register clears both its flags.
// - bits 5 and 4 set make aux a manual output equal to bit 3.
`timescale 1ns/100ps
module pia_control_lines (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // processor access
  input wire pia_lines_pkg::cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  // port data lines
  input wire logic [7:0] port_a_lines,
  output logic [7:0] port_b_lines,
  // port A control lines
  input wire logic port_a_strobe_in,
  input wire logic port_a_aux_line_in,
  output logic port_a_aux_line_out,
  output logic port_a_aux_line_oe,
  // port B control lines
  input wire logic port_b_strobe_in,
  input wire logic port_b_aux_line_in,
  output logic port_b_aux_line_out,
  output logic port_b_aux_line_oe,
  // interrupt requests
  output logic port_a_irq_n,
  output logic port_b_irq_n
);

  logic [5:0] ctrl_a_q;
  logic [5:0] ctrl_b_q;
  logic flag_a7_q;
  logic flag_a6_q;
  logic flag_b7_q;
  logic flag_b6_q;
  logic [7:0] pa_sync1_q;
  logic [7:0] pa_sync2_q;
  logic edge_a_strobe;
  logic edge_a_aux;
  logic edge_b_strobe;
  logic edge_b_aux;
  logic read_a_data;
  logic write_b_data;
  logic read_b_data;
  logic wr_a_ctrl;
  logic wr_b_ctrl;
  logic irq_a_d;
  logic irq_b_d;
  logic read_a_ctrl;
  logic read_b_ctrl;
  logic aux_set_a;
  logic aux_set_b;
  logic flag_a7_d;
  logic flag_a6_d;
  logic flag_b7_d;
  logic flag_b6_d;
  logic [7:0] rdata_d;

  // ==========================================================
  // one register access of the given direction and select
  function automatic logic access_hit(input pia_lines_pkg::cpu_req_t req, input logic rd, input logic [1:0] rs);
    logic hit;
    hit = req.sel && (req.rd == rd) && (req.rs == rs);
    return hit;
  endfunction

  // ==========================================================
  // access decode
  assign read_a_data = access_hit(cpu_req, 1'b1, pia_lines_pkg::RS_PORT_A_DATA);
  assign read_a_ctrl = access_hit(cpu_req, 1'b1, pia_lines_pkg::RS_PORT_A_CTRL);
  assign read_b_data = access_hit(cpu_req, 1'b1, pia_lines_pkg::RS_PORT_B_DATA);
  assign read_b_ctrl = access_hit(cpu_req, 1'b1, pia_lines_pkg::RS_PORT_B_CTRL);
  assign write_b_data = access_hit(cpu_req, 1'b0, pia_lines_pkg::RS_PORT_B_DATA);
  assign wr_a_ctrl = access_hit(cpu_req, 1'b0, pia_lines_pkg::RS_PORT_A_CTRL);
  assign wr_b_ctrl = access_hit(cpu_req, 1'b0, pia_lines_pkg::RS_PORT_B_CTRL);

  // ==========================================================
  // edge detectors
  line_edge_detect u_edge_a_strobe (
    .clk_sys(clk_sys),
    .reset(reset),
    .line_in(port_a_strobe_in),
    .rising_sel(ctrl_a_q[pia_lines_pkg::CTRL_STROBE_RISING]),
    .edge_seen(edge_a_strobe)
  );

  line_edge_detect u_edge_a_aux (
    .clk_sys(clk_sys),
    .reset(reset),
    .line_in(port_a_aux_line_in),
    .rising_sel(ctrl_a_q[pia_lines_pkg::CTRL_AUX_BIT4]),
    .edge_seen(edge_a_aux)
  );

  line_edge_detect u_edge_b_strobe (
    .clk_sys(clk_sys),
    .reset(reset),
    .line_in(port_b_strobe_in),
    .rising_sel(ctrl_b_q[pia_lines_pkg::CTRL_STROBE_RISING]),
    .edge_seen(edge_b_strobe)
  );

  line_edge_detect u_edge_b_aux (
    .clk_sys(clk_sys),
    .reset(reset),
    .line_in(port_b_aux_line_in),
    .rising_sel(ctrl_b_q[pia_lines_pkg::CTRL_AUX_BIT4]),
    .edge_seen(edge_b_aux)
  );

  // ==========================================================
  // control registers, writable bits 5..0
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_a_q <= pia_lines_pkg::CTRL_RESET;
    end else if (wr_a_ctrl) begin
      ctrl_a_q <= cpu_req.wdata[pia_lines_pkg::CTRL_WRITABLE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_b_q <= pia_lines_pkg::CTRL_RESET;
    end else if (wr_b_ctrl) begin
      ctrl_b_q <= cpu_req.wdata[pia_lines_pkg::CTRL_WRITABLE_W-1:0];
    end
  end

  // ==========================================================
  // flag next value: a set beats the clearing read in the same cycle
  function automatic logic flag_next(input logic q, input logic set, input logic clr);
    logic n;
    n = q;
    if (set) begin
      n = 1'b1;
    end else if (clr) begin
      n = 1'b0;
    end
    return n;
  endfunction

  // ==========================================================
  // aux edges only count in input mode
  assign aux_set_a = edge_a_aux && !ctrl_a_q[pia_lines_pkg::CTRL_AUX_OUTPUT];
  assign aux_set_b = edge_b_aux && !ctrl_b_q[pia_lines_pkg::CTRL_AUX_OUTPUT];

  // ==========================================================
  // flag next values
  always_comb begin
    flag_a7_d = flag_next(flag_a7_q, edge_a_strobe, read_a_data);
    flag_a6_d = flag_next(flag_a6_q, aux_set_a, read_a_data);
    flag_b7_d = flag_next(flag_b7_q, edge_b_strobe, read_b_data);
    flag_b6_d = flag_next(flag_b6_q, aux_set_b, read_b_data);
  end

  // ==========================================================
  // port A flags
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_a7_q <= 1'b0;
    end else begin
      flag_a7_q <= flag_a7_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_a6_q <= 1'b0;
    end else begin
      flag_a6_q <= flag_a6_d;
    end
  end

  // ==========================================================
  // port B flags
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_b7_q <= 1'b0;
    end else begin
      flag_b7_q <= flag_b7_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_b6_q <= 1'b0;
    end else begin
      flag_b6_q <= flag_b6_d;
    end
  end

  // ==========================================================
  // interrupt requests
  function automatic logic irq_level(input logic f7, input logic f6, input logic [5:0] ctrl);
    logic strobe_irq;
    logic aux_irq;
    strobe_irq = f7 && ctrl[pia_lines_pkg::CTRL_STROBE_IRQ_EN];
    aux_irq = f6 && ctrl[pia_lines_pkg::CTRL_AUX_BIT3] && !ctrl[pia_lines_pkg::CTRL_AUX_OUTPUT];
    return strobe_irq || aux_irq;
  endfunction

  assign irq_a_d = irq_level(flag_a7_q, flag_a6_q, ctrl_a_q);
  assign irq_b_d = irq_level(flag_b7_q, flag_b6_q, ctrl_b_q);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port_a_irq_n <= pia_lines_pkg::IRQ_IDLE_N;
      port_b_irq_n <= pia_lines_pkg::IRQ_IDLE_N;
    end else begin
      port_a_irq_n <= ~irq_a_d;
      port_b_irq_n <= ~irq_b_d;
    end
  end

  // ==========================================================
  // aux line outputs: A on data reads, B on data writes
  aux_line_drive u_aux_a (
    .clk_sys(clk_sys),
    .reset(reset),
    .ctrl(ctrl_a_q),
    .strobe_edge(edge_a_strobe),
    .data_event(read_a_data),
    .line_out(port_a_aux_line_out),
    .line_oe(port_a_aux_line_oe)
  );

  aux_line_drive u_aux_b (
    .clk_sys(clk_sys),
    .reset(reset),
    .ctrl(ctrl_b_q),
    .strobe_edge(edge_b_strobe),
    .data_event(write_b_data),
    .line_out(port_b_aux_line_out),
    .line_oe(port_b_aux_line_oe)
  );

  // ==========================================================
  // port data: A input synchronised, B output latch
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pa_sync1_q <= pia_lines_pkg::DATA_RESET;
      pa_sync2_q <= pia_lines_pkg::DATA_RESET;
    end else begin
      pa_sync1_q <= port_a_lines;
      pa_sync2_q <= pa_sync1_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port_b_lines <= pia_lines_pkg::DATA_RESET;
    end else if (write_b_data) begin
      port_b_lines <= cpu_req.wdata;
    end
  end

  // ==========================================================
  // control register image: flags above the writable bits
  function automatic logic [7:0] ctrl_image(input logic f7, input logic f6, input logic [5:0] ctrl);
    logic [7:0] img;
    img = {f7, f6, ctrl};
    return img;
  endfunction

  // ==========================================================
  // read data, captured before the clearing read takes effect
  always_comb begin
    rdata_d = cpu_rdata;
    if (read_a_data) begin
      rdata_d = pa_sync2_q;
    end else if (read_a_ctrl) begin
      rdata_d = ctrl_image(flag_a7_q, flag_a6_q, ctrl_a_q);
    end else if (read_b_data) begin
      rdata_d = port_b_lines;
    end else if (read_b_ctrl) begin
      rdata_d = ctrl_image(flag_b7_q, flag_b6_q, ctrl_b_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cpu_rdata <= pia_lines_pkg::DATA_RESET;
    end else begin
      cpu_rdata <= rdata_d;
    end
  end

endmodule

// [rtl/pia_lines_pkg.sv]
// shared constants, types and decode for the control-line block
package pia_lines_pkg;

  // ==========================================================
  // register select codes
  localparam logic [1:0] RS_PORT_A_DATA = 2'h0;
  localparam logic [1:0] RS_PORT_A_CTRL = 2'h1;
  localparam logic [1:0] RS_PORT_B_DATA = 2'h2;
  localparam logic [1:0] RS_PORT_B_CTRL = 2'h3;

  // ==========================================================
  // control register field positions
  localparam int CTRL_STROBE_IRQ_EN = 0;
  localparam int CTRL_STROBE_RISING = 1;
  localparam int CTRL_AUX_BIT3 = 3;
  localparam int CTRL_AUX_BIT4 = 4;
  localparam int CTRL_AUX_OUTPUT = 5;
  localparam int CTRL_AUX_FLAG = 6;
  localparam int CTRL_STROBE_FLAG = 7;
  localparam int CTRL_WRITABLE_W = 6;

  // ==========================================================
  // values after reset
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic IRQ_IDLE_N = 1'b1;

  // ==========================================================
  // processor access carrier
  typedef struct packed {
    logic sel;
    logic rd;
    logic [1:0] rs;
    logic [7:0] wdata;
  } cpu_req_t;

  typedef enum {
    AUX_INPUT,
    AUX_HANDSHAKE,
    AUX_PULSE,
    AUX_MANUAL
  } aux_mode_t;

  // ==========================================================
  // aux line mode from control bits 5..3
  function automatic aux_mode_t aux_mode(input logic [5:0] ctrl);
    aux_mode_t m;
    m = AUX_INPUT;
    if (ctrl[CTRL_AUX_OUTPUT] && ctrl[CTRL_AUX_BIT4]) begin
      m = AUX_MANUAL;
    end else if (ctrl[CTRL_AUX_OUTPUT] && ctrl[CTRL_AUX_BIT3]) begin
      m = AUX_PULSE;
    end else if (ctrl[CTRL_AUX_OUTPUT]) begin
      m = AUX_HANDSHAKE;
    end
    return m;
  endfunction

endpackage

// [tb/periph_model.sv]
// peripheral model answering the control lines
`timescale 1ns/100ps
module periph_model (
  // clock and settings
  input wire logic clk_sys,
  input wire logic [3:0] delay,
  input wire logic [1:0] aux_lvl,
  // lines from the block
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  // lines to the block
  output logic a_stb,
  output logic b_stb,
  output logic a_in,
  output logic b_in,
  output logic [7:0] a_data
);
  // wire level seen by both parties
  assign a_in = a_oe ? a_out : aux_lvl[0];
  assign b_in = b_oe ? b_out : aux_lvl[1];
  initial begin
    a_stb = 1'b1;
    b_stb = 1'b1;
    a_data = 8'h5A;
  end
  // new data only once the line is low, then a strobe pulse
  always @(negedge a_out) begin
    repeat (delay) @(posedge clk_sys);
    a_data <= a_data + 8'h11;
    repeat (2) @(posedge clk_sys);
    a_stb <= 1'b0;
    repeat (3) @(posedge clk_sys);
    a_stb <= 1'b1;
  end
  // data taken: acknowledge with a strobe pulse
  always @(negedge b_out) begin
    repeat (delay + 4'h2) @(posedge clk_sys);
    b_stb <= 1'b0;
    repeat (3) @(posedge clk_sys);
    b_stb <= 1'b1;
  end
endmodule

// [tb/peripheral_handshake_control_lines_test.sv]
// self-checking bench for the control-line block
`timescale 1ns/100ps
module peripheral_handshake_control_lines_test;
  logic clk_sys, reset, rd_seen, a_stb, b_stb, a_in, b_in, a_out, b_out, a_oe, b_oe, a_irq_n, b_irq_n;
  pia_lines_pkg::cpu_req_t cpu_req;
  logic [7:0] cpu_rdata, a_data, b_lines, d, cfg;
  logic [3:0] delay;
  logic [1:0] aux_lvl;
  logic [8:0] exp_q[$];
  int err_count;
  int comparisons;
  pia_control_lines uut (.clk_sys(clk_sys), .reset(reset), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .port_a_lines(a_data), .port_b_lines(b_lines), .port_a_strobe_in(a_stb), .port_a_aux_line_in(a_in),
    .port_a_aux_line_out(a_out), .port_a_aux_line_oe(a_oe), .port_b_strobe_in(b_stb),
    .port_b_aux_line_in(b_in), .port_b_aux_line_out(b_out), .port_b_aux_line_oe(b_oe),
    .port_a_irq_n(a_irq_n), .port_b_irq_n(b_irq_n));
  periph_model peer (.clk_sys(clk_sys), .delay(delay), .aux_lvl(aux_lvl), .a_out(a_out), .a_oe(a_oe),
    .b_out(b_out), .b_oe(b_oe), .a_stb(a_stb), .b_stb(b_stb), .a_in(a_in), .b_in(b_in), .a_data(a_data));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task finish_test;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one processor access; a read notes its expected byte
  task acc(input logic r, input logic [1:0] rs, input logic [7:0] wd, input logic [8:0] e);
    @(posedge clk_sys);
    cpu_req <= '{sel: 1'b1, rd: r, rs: rs, wdata: wd};
    if (r) begin
      exp_q.push_back(e);
    end
    @(posedge clk_sys);
    cpu_req.sel <= 1'b0;
  endtask
  // ==========================================================
  // read data monitor
  always @(posedge clk_sys) begin
    if (rd_seen && exp_q.size() > 0) begin
      if (exp_q[0][8]) begin
        check(cpu_rdata, exp_q[0][7:0]);
      end
      void'(exp_q.pop_front());
    end
    rd_seen <= cpu_req.sel && cpu_req.rd && !reset;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    finish_test;
  end
  // ==========================================================
  // main sequence
  initial begin
    cpu_req = '0;
    reset = 1'b1;
    rd_seen = 1'b0;
    delay = 4'h0;
    aux_lvl = 2'h3;
    err_count = 0;
    comparisons = 0;
    void'($urandom(32'hBFFE));
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    check({2'h0, a_out, b_out, a_oe, b_oe, a_irq_n, b_irq_n}, 8'h33);
    check(b_lines, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        delay <= 4'($urandom_range(7));
        acc(1'b0, 2'(2 * p + 1), 8'h38 | 8'(c), 9'h0);
        repeat (20) @(posedge clk_sys);
        #1;
        check(8'(p ? b_out : a_out), 8'h01);
        acc(1'b0, 2'(2 * p + 1), 8'h30 | 8'(c), 9'h0);
        repeat (20) @(posedge clk_sys);
        #1;
        check(8'(p ? b_irq_n : a_irq_n), 8'(!c[0]));
        acc(1'b1, 2'(2 * p + 1), 8'h00, 9'h1B0 | 9'(c));
        acc(1'b1, 2'(2 * p), 8'h00, {p == 0, a_data});
        repeat (3) @(posedge clk_sys);
        #1;
        check(8'(p ? b_irq_n : a_irq_n), 8'h01);
      end
    end
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        cfg = 8'(c) << 3;
        acc(1'b0, 2'(2 * p + 1), 8'hC0 | cfg, 9'h0);
        repeat (4) @(posedge clk_sys);
        aux_lvl[p] <= 1'b0;
        repeat (6) @(posedge clk_sys);
        aux_lvl[p] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        check(8'(p ? b_irq_n : a_irq_n), 8'(!cfg[3]));
        acc(1'b1, 2'(2 * p + 1), 8'h00, 9'h140 | 9'(cfg));
        acc(1'b1, 2'(2 * p), 8'h00, {p == 0, a_data});
        acc(1'b1, 2'(2 * p + 1), 8'h00, 9'h100 | 9'(cfg));
      end
    end
    acc(1'b0, pia_lines_pkg::RS_PORT_A_CTRL, 8'h28, 9'h0);
    acc(1'b1, pia_lines_pkg::RS_PORT_A_DATA, 8'h00, {1'b1, a_data});
    #1;
    check(8'(a_out), 8'h00);
    @(posedge clk_sys);
    #1;
    check(8'(a_out), 8'h01);
    repeat (20) @(posedge clk_sys);
    acc(1'b0, pia_lines_pkg::RS_PORT_A_CTRL, 8'h20, 9'h0);
    acc(1'b1, pia_lines_pkg::RS_PORT_A_DATA, 8'h00, {1'b1, a_data});
    #1;
    check(8'(a_out), 8'h00);
    repeat (20) @(posedge clk_sys);
    #1;
    check(8'(a_out), 8'h01);
    acc(1'b1, pia_lines_pkg::RS_PORT_A_CTRL, 8'h00, 9'h1A0);
    acc(1'b1, pia_lines_pkg::RS_PORT_A_DATA, 8'h00, {1'b1, a_data});
    acc(1'b0, pia_lines_pkg::RS_PORT_B_CTRL, 8'h20, 9'h0);
    acc(1'b1, pia_lines_pkg::RS_PORT_B_DATA, 8'h00, 9'h0);
    #1;
    check(8'(b_out), 8'h01);
    check(8'(b_oe), 8'h01);
    d = 8'($urandom);
    acc(1'b0, pia_lines_pkg::RS_PORT_B_DATA, d, 9'h0);
    #1;
    check(8'(b_out), 8'h00);
    check(b_lines, d);
    repeat (20) @(posedge clk_sys);
    #1;
    check(8'(b_out), 8'h01);
    acc(1'b0, pia_lines_pkg::RS_PORT_B_CTRL, 8'h28, 9'h0);
    acc(1'b0, pia_lines_pkg::RS_PORT_B_DATA, ~d, 9'h0);
    #1;
    check(8'(b_out), 8'h00);
    @(posedge clk_sys);
    #1;
    check(8'(b_out), 8'h01);
    repeat (20) @(posedge clk_sys);
    finish_test;
  end
endmodule

// [tb/pia_control_lines_checker.sv]
// assertion checker for the control-line block
`timescale 1ns/100ps
module pia_control_lines_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // processor access
  input wire pia_lines_pkg::cpu_req_t cpu_req,
  // control lines
  input wire logic port_a_strobe_in,
  input wire logic port_a_aux_line_out,
  input wire logic port_a_aux_line_oe,
  input wire logic port_b_aux_line_out,
  // interrupt request
  input wire logic port_a_irq_n
);
  // ==========================================================
  // shadow of the writable control bits
  logic [5:0] ctl_a_q;
  logic [5:0] ctl_b_q;
  logic rd_a;
  logic wr_b;
  assign rd_a = cpu_req.sel && cpu_req.rd && cpu_req.rs == pia_lines_pkg::RS_PORT_A_DATA;
  assign wr_b = cpu_req.sel && !cpu_req.rd && cpu_req.rs == pia_lines_pkg::RS_PORT_B_DATA;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctl_a_q <= pia_lines_pkg::CTRL_RESET;
    end else if (cpu_req.sel && !cpu_req.rd && cpu_req.rs == pia_lines_pkg::RS_PORT_A_CTRL) begin
      ctl_a_q <= cpu_req.wdata[5:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctl_b_q <= pia_lines_pkg::CTRL_RESET;
    end else if (cpu_req.sel && !cpu_req.rd && cpu_req.rs == pia_lines_pkg::RS_PORT_B_CTRL) begin
      ctl_b_q <= cpu_req.wdata[5:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================
  // sequences
  sequence a_pulse_read;
    rd_a && ctl_a_q[5:3] == 3'h5;
  endsequence
  sequence a_strobe_armed;
    $fell(port_a_strobe_in) && ctl_a_q[1:0] == 2'h1;
  endsequence
  sequence a_manual_held;
    ctl_a_q[5:4] == 2'h3 ##1 $stable(ctl_a_q);
  endsequence
  // ==========================================================
  // assertions
  a_pulse_on_read: assert property (a_pulse_read |=> !port_a_aux_line_out ##1 port_a_aux_line_out)
    else $error("port A pulse wrong");
  a_hs_read_low: assert property (rd_a && ctl_a_q[5:3] == 3'h4 |=> !port_a_aux_line_out)
    else $error("port A handshake not low");
  a_hs_write_low: assert property (wr_b && ctl_b_q[5:3] == 3'h4 |=> !port_b_aux_line_out)
    else $error("port B handshake not low");
  a_pulse_on_write: assert property (wr_b && ctl_b_q[5:3] == 3'h5 |=> !port_b_aux_line_out ##1 port_b_aux_line_out)
    else $error("port B pulse wrong");
  a_strobe_irq_low: assert property (a_strobe_armed ##0 (ctl_a_q[1:0] == 2'h1 && !rd_a)[*5] |-> !port_a_irq_n)
    else $error("port A request not low");
  a_irq_held_off: assert property ((!ctl_a_q[0] && (!ctl_a_q[3] || ctl_a_q[5]))[*2] |-> port_a_irq_n)
    else $error("port A request low while disabled");
  a_manual_level: assert property (a_manual_held |-> port_a_aux_line_out == ctl_a_q[3])
    else $error("manual level wrong");
  a_oe_mode: assert property (1'b1 |=> port_a_aux_line_oe == $past(ctl_a_q[5]))
    else $error("drive enable wrong");
  a_input_idle: assert property (!ctl_b_q[5] ##1 !ctl_b_q[5] |-> port_b_aux_line_out)
    else $error("port B line driven in input mode");
endmodule

bind pia_control_lines pia_control_lines_checker chk (.clk_sys(clk_sys), .reset(reset), .cpu_req(cpu_req),
  .port_a_strobe_in(port_a_strobe_in), .port_a_aux_line_out(port_a_aux_line_out),
  .port_a_aux_line_oe(port_a_aux_line_oe), .port_b_aux_line_out(port_b_aux_line_out),
  .port_a_irq_n(port_a_irq_n));
